/* File: rtl/bcbx_pkg.sv */
// constants and types shared by the bit-clear and flag-branch executor
package bcbx_pkg;
    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_BANK   = 8'h04;
    localparam logic [7:0] OFS_INDEX  = 8'h08;
    localparam logic [7:0] OFS_PC     = 8'h0c;
    localparam logic [7:0] OFS_INSTR  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MADDR  = 8'h18;
    localparam logic [7:0] OFS_MDATA  = 8'h1c;
    // control field positions
    localparam int CTRL_EXT_BIT   = 0;
    localparam int CTRL_NEG_BIT   = 1;
    localparam int CTRL_CARRY_BIT = 2;
    // status field positions
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_TAKEN_BIT = 1;
    localparam int STAT_BADOP_BIT = 2;
    localparam int STAT_CYC_LSB   = 8;
    // widths
    localparam int PC_W   = 21;
    localparam int DADR_W = 12;
    localparam int BANK_W = 4;
    // values after reset
    localparam logic [PC_W-1:0]   PC_RST    = 21'h000000;
    localparam logic [BANK_W-1:0] BANK_RST  = 4'h0;
    localparam logic [2:0]        CTRL_RST  = 3'h0;
    // opcode patterns
    localparam logic [3:0] OP_BITCLR   = 4'h9;
    localparam logic [7:0] OP_BRNEG    = 8'he6;
    localparam logic [7:0] OP_BRNCARRY = 8'he3;
    localparam logic [7:0] OP_BRCARRY  = 8'he2;
    // addressing constants
    localparam logic [7:0] IDX_LIMIT    = 8'h5f;
    localparam logic [7:0] ACC_SPLIT    = 8'h80;
    localparam logic [3:0] ACC_HI_BANK  = 4'hf;
    localparam logic [3:0] ACC_LO_BANK  = 4'h0;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    // timing counts and bus response codes
    localparam logic [1:0] PHASE_Q1   = 2'h0;
    localparam logic [1:0] PHASE_Q2   = 2'h1;
    localparam logic [1:0] PHASE_Q3   = 2'h2;
    localparam logic [1:0] PHASE_Q4   = 2'h3;
    localparam logic [7:0] CYC_ONE    = 8'h01;
    localparam logic [7:0] CYC_TWO    = 8'h02;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // execution states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_NOP  = 2'b10
    } bcbx_state_t;

    // decoded instruction word
    typedef struct packed {
        logic [3:0] group;
        logic [2:0] bitIdx;
        logic       access;
        logic [7:0] literal;
    } bcbx_instr_t;

    // request to the data memory
    typedef struct packed {
        logic              wrEn;
        logic [DADR_W-1:0] addr;
        logic [7:0]        wrData;
    } bcbx_ramreq_t;
endpackage

/* File: rtl/bcbx_ram.sv */
// banked data memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module bcbx_ram (
    input  wire logic                   ref_clk,
    input  wire bcbx_pkg::bcbx_ramreq_t req,
    output var  logic [7:0]             rdData
);
    logic [7:0] mem [0:(1<<bcbx_pkg::DADR_W)-1];

    // write port and registered read port
    always_ff @(posedge ref_clk) begin
        if (req.wrEn) begin
            mem[req.addr] <= req.wrData;
        end
        rdData <= mem[req.addr];
    end
endmodule
`default_nettype wire

/* File: rtl/bcbx_exec.sv */
// bit-clear and flag-branch executor with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module bcbx_exec (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // software-visible state
    logic [2:0]                    ctrl_q;
    logic [bcbx_pkg::BANK_W-1:0]   bank_q;
    logic [bcbx_pkg::DADR_W-1:0]   index_q;
    logic [bcbx_pkg::PC_W-1:0]     pc_q;
    logic [bcbx_pkg::PC_W-1:0]     pc_d;
    bcbx_pkg::bcbx_instr_t         instr_q;
    logic [bcbx_pkg::DADR_W-1:0]   maddr_q;
    logic                          taken_q;
    logic                          badOp_q;
    logic [7:0]                    cycles_q;
    bcbx_pkg::bcbx_state_t         state_q;
    bcbx_pkg::bcbx_state_t         state_d;
    logic [1:0]                    phase_q;
    // bus state
    logic        awHeld_q;
    logic        wHeld_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        rPend_q;
    logic [7:0]  arAddr_q;
    logic        awHeld_d;
    logic        wHeld_d;
    logic        bvalid_d;
    logic        rvalid_d;
    logic        rPend_d;
    // memory path
    bcbx_pkg::bcbx_ramreq_t ramReq;
    logic [7:0]             ramRd;

    bcbx_ram u_ram (
        .ref_clk (ref_clk),
        .req     (ramReq),
        .rdData  (ramRd)
    );

    // opcode decode
    wire busy     = (state_q != bcbx_pkg::ST_IDLE);
    wire isBitClr = (instr_q.group == bcbx_pkg::OP_BITCLR);
    wire [7:0] upper = {instr_q.group, instr_q.bitIdx, instr_q.access};
    wire isBrNeg  = (upper == bcbx_pkg::OP_BRNEG);
    wire isBrNc   = (upper == bcbx_pkg::OP_BRNCARRY);
    wire isBrC    = (upper == bcbx_pkg::OP_BRCARRY);
    wire negFlag  = ctrl_q[bcbx_pkg::CTRL_NEG_BIT];
    wire carryFlag = ctrl_q[bcbx_pkg::CTRL_CARRY_BIT];
    wire takeBr   = (isBrNeg & negFlag) | (isBrNc & ~carryFlag)
                  | (isBrC & carryFlag);

    // target from incremented counter plus 2n
    wire [bcbx_pkg::PC_W-1:0] brOffs =
        {{(bcbx_pkg::PC_W-9){instr_q.literal[7]}}, instr_q.literal, 1'b0};
    wire [bcbx_pkg::PC_W-1:0] brTarget = pc_q + brOffs;

    // indexed literal offset in extended mode
    wire useIndexed = ctrl_q[bcbx_pkg::CTRL_EXT_BIT] & ~instr_q.access
                    & (instr_q.literal <= bcbx_pkg::IDX_LIMIT);
    wire [3:0] accBank = (instr_q.literal >= bcbx_pkg::ACC_SPLIT) ?
                         bcbx_pkg::ACC_HI_BANK : bcbx_pkg::ACC_LO_BANK;
    wire [bcbx_pkg::DADR_W-1:0] effAddr =
        useIndexed ? index_q + {4'h0, instr_q.literal} :
        instr_q.access ? {bank_q, instr_q.literal} :
        {accBank, instr_q.literal};

    // clear the chosen bit, written in Q4
    wire [7:0] clrMask = ~(8'h01 << instr_q.bitIdx);
    wire execWr = (state_q == bcbx_pkg::ST_RUN) & isBitClr
                & (phase_q == bcbx_pkg::PHASE_Q4);
    wire [bcbx_pkg::DADR_W-1:0] curAddr = busy ? effAddr : maddr_q;

    // register read view
    function automatic logic [31:0] regView(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            bcbx_pkg::OFS_CTRL:   v[2:0] = ctrl_q;
            bcbx_pkg::OFS_BANK:   v[bcbx_pkg::BANK_W-1:0] = bank_q;
            bcbx_pkg::OFS_INDEX:  v[bcbx_pkg::DADR_W-1:0] = index_q;
            bcbx_pkg::OFS_PC:     v[bcbx_pkg::PC_W-1:0] = pc_q;
            bcbx_pkg::OFS_INSTR:  v[15:0] = instr_q;
            bcbx_pkg::OFS_STATUS: begin
                v[bcbx_pkg::STAT_BUSY_BIT]  = busy;
                v[bcbx_pkg::STAT_TAKEN_BIT] = taken_q;
                v[bcbx_pkg::STAT_BADOP_BIT] = badOp_q;
                v[bcbx_pkg::STAT_CYC_LSB +: 8] = cycles_q;
            end
            bcbx_pkg::OFS_MADDR:  v[bcbx_pkg::DADR_W-1:0] = maddr_q;
            bcbx_pkg::OFS_MDATA:  v[7:0] = ramRd;
            default:              v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= bcbx_pkg::OFS_MDATA);
    endfunction

    // write decode: both halves held and no response pending
    wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
    logic [31:0] oldWord;
    always_comb oldWord = regView(awAddr_q);
    logic [31:0] merged;
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign merged[gb*8 +: 8] = wStrb_q[gb] ?
                wData_q[gb*8 +: 8] : oldWord[gb*8 +: 8];
        end
    endgenerate
    wire [7:0] wrSel;
    assign wrSel[0] = doWrite & (awAddr_q == bcbx_pkg::OFS_CTRL);
    assign wrSel[1] = doWrite & (awAddr_q == bcbx_pkg::OFS_BANK);
    assign wrSel[2] = doWrite & (awAddr_q == bcbx_pkg::OFS_INDEX);
    assign wrSel[3] = doWrite & ~busy & (awAddr_q == bcbx_pkg::OFS_PC);
    assign wrSel[4] = doWrite & ~busy & (awAddr_q == bcbx_pkg::OFS_INSTR);
    assign wrSel[5] = 1'b0;
    assign wrSel[6] = doWrite & (awAddr_q == bcbx_pkg::OFS_MADDR);
    assign wrSel[7] = doWrite & (awAddr_q == bcbx_pkg::OFS_MDATA);

    // memory request: executor write or idle data-port write
    assign ramReq.wrEn   = execWr | (doWrite & ~busy & wrSel[7]);
    assign ramReq.addr   = curAddr;
    assign ramReq.wrData = execWr ? (ramRd & clrMask) : merged[7:0];

    // bus handshake next values
    assign awHeld_d = (awHeld_q & ~doWrite) | (s_axi_awvalid & s_axi_awready);
    assign wHeld_d  = (wHeld_q & ~doWrite) | (s_axi_wvalid & s_axi_wready);
    assign bvalid_d = doWrite | (s_axi_bvalid & ~s_axi_bready);
    assign rPend_d  = s_axi_arvalid & s_axi_arready;
    assign rvalid_d = rPend_q | (s_axi_rvalid & ~s_axi_rready);

    // write channel registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= bcbx_pkg::RESP_OKAY;
        end else begin
            awHeld_q      <= awHeld_d;
            wHeld_q       <= wHeld_d;
            s_axi_awready <= ~awHeld_d;
            s_axi_wready  <= ~wHeld_d;
            s_axi_bvalid  <= bvalid_d;
            if (doWrite) begin
                s_axi_bresp <= mapped(awAddr_q) ?
                    bcbx_pkg::RESP_OKAY : bcbx_pkg::RESP_SLVERR;
            end
        end
    end

    // captured write payloads
    always_ff @(posedge ref_clk) begin
        if (s_axi_awvalid & s_axi_awready) awAddr_q <= s_axi_awaddr;
        if (s_axi_wvalid & s_axi_wready) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end
    end

    // read channel, answer two cycles after address taken
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rPend_q       <= 1'b0;
            arAddr_q      <= 8'h00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= bcbx_pkg::RESP_OKAY;
        end else begin
            rPend_q       <= rPend_d;
            s_axi_arready <= ~(rPend_d | rvalid_d);
            s_axi_rvalid  <= rvalid_d;
            if (rPend_d) arAddr_q <= s_axi_araddr;
            if (rPend_q) begin
                s_axi_rdata <= regView(arAddr_q);
                s_axi_rresp <= mapped(arAddr_q) ?
                    bcbx_pkg::RESP_OKAY : bcbx_pkg::RESP_SLVERR;
            end
        end
    end

    // phase sequencing through Q1..Q4 and the nop cycle
    always_comb begin
        state_d = state_q;
        case (state_q)
            bcbx_pkg::ST_IDLE: begin
                if (wrSel[4]) state_d = bcbx_pkg::ST_RUN;
            end
            bcbx_pkg::ST_RUN: begin
                // taken branch adds a second cycle
                if (phase_q == bcbx_pkg::PHASE_Q4) begin
                    state_d = takeBr ? bcbx_pkg::ST_NOP : bcbx_pkg::ST_IDLE;
                end
            end
            bcbx_pkg::ST_NOP: begin
                if (phase_q == bcbx_pkg::PHASE_Q4) state_d = bcbx_pkg::ST_IDLE;
            end
            default: state_d = bcbx_pkg::ST_IDLE;
        endcase
    end

    // program counter: advance in Q1, branch target in Q4
    always_comb begin
        pc_d = pc_q;
        if (wrSel[3]) begin
            pc_d = merged[bcbx_pkg::PC_W-1:0];
        end else if (state_q == bcbx_pkg::ST_RUN) begin
            if (phase_q == bcbx_pkg::PHASE_Q1) begin
                pc_d = pc_q + bcbx_pkg::PC_STEP;
            end else if (phase_q == bcbx_pkg::PHASE_Q4 && takeBr) begin
                pc_d = brTarget;
            end
        end
    end

    // executor and control registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q  <= bcbx_pkg::ST_IDLE;
            phase_q  <= bcbx_pkg::PHASE_Q1;
            pc_q     <= bcbx_pkg::PC_RST;
            ctrl_q   <= bcbx_pkg::CTRL_RST;
            bank_q   <= bcbx_pkg::BANK_RST;
            index_q  <= '0;
            maddr_q  <= '0;
            instr_q  <= '0;
            taken_q  <= 1'b0;
            badOp_q  <= 1'b0;
            cycles_q <= 8'h00;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            phase_q <= busy ? phase_q + 2'h1 : bcbx_pkg::PHASE_Q1;
            if (wrSel[0]) ctrl_q <= merged[2:0];
            if (wrSel[1]) bank_q <= merged[bcbx_pkg::BANK_W-1:0];
            if (wrSel[2]) index_q <= merged[bcbx_pkg::DADR_W-1:0];
            if (wrSel[6]) maddr_q <= merged[bcbx_pkg::DADR_W-1:0];
            if (wrSel[4]) begin
                instr_q <= merged[15:0];
                taken_q <= 1'b0;
            end
            // record one or two cycles used
            if (state_q == bcbx_pkg::ST_RUN
                && phase_q == bcbx_pkg::PHASE_Q4) begin
                taken_q  <= takeBr;
                badOp_q  <= ~(isBitClr | isBrNeg | isBrNc | isBrC);
                cycles_q <= takeBr ? bcbx_pkg::CYC_TWO : bcbx_pkg::CYC_ONE;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/bcbx_exec_asserts.sv */
// handshake and status checks for the executor
`timescale 1ns/1ns
`default_nettype none
module bcbx_exec_asserts (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    logic [7:0] rdAdr_q;
    wire        isStat;

    // address of the read under way
    always_ff @(posedge ref_clk) begin
        if (s_axi_arvalid && s_axi_arready)
            rdAdr_q <= s_axi_araddr;
    end
    assign isStat = (rdAdr_q == bcbx_pkg::OFS_STATUS);

    // read taken, ready drops, data one cycle later
    sequence s_arTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rdAnswer;
        !s_axi_arready ##1 s_axi_rvalid;
    endsequence
    property p_rd_lat;
        s_arTake |=> s_rdAnswer;
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    property p_aw_drop;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    property p_unmapped;
        s_axi_rvalid && rdAdr_q > bcbx_pkg::OFS_MDATA
            |-> s_axi_rresp == bcbx_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    property p_cyc_taken;
        s_axi_rvalid && isStat && s_axi_rdata[1:0] == 2'h2
            |-> s_axi_rdata[15:8] == bcbx_pkg::CYC_TWO;
    endproperty
    property p_cyc_fall;
        s_axi_rvalid && isStat && s_axi_rdata[2:0] == 3'h0
            && s_axi_rdata[15:8] != 8'h00
            |-> s_axi_rdata[15:8] == bcbx_pkg::CYC_ONE;
    endproperty

    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_wr_hold: assert property (p_wr_hold) else $error("write resp moved");
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    a_aw_drop: assert property (p_aw_drop) else $error("awready stayed");
    a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
    a_cyc_taken: assert property (p_cyc_taken) else $error("taken count");
    a_cyc_fall: assert property (p_cyc_fall) else $error("plain count");
endmodule
bind bcbx_exec bcbx_exec_asserts u_chk (
    .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

/* File: bench/bcbx_exec_tb.sv */
// self-checking bench for the bit-clear and branch executor
`timescale 1ns/1ns
`default_nettype none
module bcbx_exec_tb;
    logic        ref_clk, srst, awValid, awReady, wValid, wReady;
    logic        bValid, bReady, arValid, arReady, rValid, rReady;
    logic [7:0]  awAddr, arAddr;
    logic [31:0] wData, rData, d, st;
    logic [3:0]  wStrb;
    logic [1:0]  bResp, rResp, resp;
    int          failures = 0;
    int          compares = 0;

    bcbx_exec dut (
        .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady)
    );

    // clock at 125 MHz
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // cut a hung handshake short
    task automatic guard(input int n);
        if (n > 100) begin
            failures++;
            $display("ERROR handshake expected answer seen timeout");
            conclude();
        end
    endtask

    // bus write: address and data together, late bready
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bit aDone;
        bit dDone;
        aDone = 1'b0;
        dDone = 1'b0;
        awAddr <= a;
        wData <= v;
        awValid <= 1'b1;
        wValid <= 1'b1;
        for (int n = 0; !(aDone && dDone); n++) begin
            @(posedge ref_clk);
            guard(n);
            if (awReady && !aDone) begin
                aDone = 1'b1;
                awValid <= 1'b0;
            end
            if (wReady && !dDone) begin
                dDone = 1'b1;
                wValid <= 1'b0;
            end
        end
        for (int n = 0; n >= 0; n++) begin
            @(posedge ref_clk);
            guard(n);
            if (bValid && bReady) break;
            bReady <= bValid;
        end
        resp = bResp;
        bReady <= 1'b0;
    endtask

    // bus read with late rready
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        arAddr <= a;
        arValid <= 1'b1;
        for (int n = 0; n >= 0; n++) begin
            @(posedge ref_clk);
            guard(n);
            if (arReady) break;
        end
        arValid <= 1'b0;
        for (int n = 0; n >= 0; n++) begin
            @(posedge ref_clk);
            guard(n);
            if (rValid && rReady) break;
            rReady <= rValid;
        end
        v = rData;
        resp = rResp;
        rReady <= 1'b0;
    endtask

    // wait until the instruction retires
    task automatic poll();
        int n;
        n = 0;
        do begin
            rd(bcbx_pkg::OFS_STATUS, st);
            guard(n);
            n++;
        end while (st[bcbx_pkg::STAT_BUSY_BIT] !== 1'b0);
    endtask

    // bit clear on a byte preset to all ones
    task automatic clr(input logic [2:0] c, input logic [11:0] idx,
                       input logic [15:0] op, input logic [11:0] eff);
        wr(bcbx_pkg::OFS_CTRL, {29'h0, c});
        wr(bcbx_pkg::OFS_INDEX, {20'h0, idx});
        wr(bcbx_pkg::OFS_MADDR, {20'h0, eff});
        wr(bcbx_pkg::OFS_MDATA, 32'hff);
        wr(bcbx_pkg::OFS_INSTR, {16'h0, op});
        poll();
        rd(bcbx_pkg::OFS_MDATA, d);
        check("cleared byte", d, {24'h0, ~(8'h01 << op[11:9])});
        rd(bcbx_pkg::OFS_CTRL, d);
        check("flags kept", d, {29'h0, c});
        check("bclr status", st, 32'h100);
    endtask

    // branch from pc; poke writes PC while busy
    task automatic br(input logic [2:0] c, input logic [20:0] pc,
                      input logic [15:0] op, input bit tk, input bit poke);
        logic [20:0] exp;
        exp = pc + 21'h2 + (tk ? {{12{op[7]}}, op[7:0], 1'b0} : 21'h0);
        wr(bcbx_pkg::OFS_CTRL, {29'h0, c});
        wr(bcbx_pkg::OFS_PC, {11'h0, pc});
        wr(bcbx_pkg::OFS_INSTR, {16'h0, op});
        if (poke) begin
            wr(bcbx_pkg::OFS_PC, 32'h0);
            check("busy pc write resp", resp, bcbx_pkg::RESP_OKAY);
        end
        poll();
        rd(bcbx_pkg::OFS_PC, d);
        check("branch pc", d, {11'h0, exp});
        check("branch status", st, tk ? 32'h202 : 32'h100);
    endtask

    // main sequence
    initial begin
        srst <= 1'b1;
        {awValid, wValid, bReady, arValid, rReady} <= 5'h0;
        awAddr <= 8'h00;
        arAddr <= 8'h00;
        wData <= 32'h0;
        wStrb <= 4'hf;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), d);
            check("reset value", d, 32'h0);
        end
        rd(8'h40, d);
        check("unmapped resp", resp, bcbx_pkg::RESP_SLVERR);
        $display("test reset done");
        wr(bcbx_pkg::OFS_BANK, 32'h3);
        for (int b = 0; b < 8; b++)
            clr(3'h6, 12'h0, {4'h9, 3'(b), 1'b1, 8'h45}, 12'h345);
        clr(3'h0, 12'h0, 16'h9e20, 12'h020);
        clr(3'h0, 12'h0, 16'h9e90, 12'hf90);
        clr(3'h1, 12'hff0, 16'h9e5f, 12'h04f);
        clr(3'h1, 12'hff0, 16'h9e60, 12'h060);
        clr(3'h1, 12'hff0, 16'h9f05, 12'h305);
        $display("test bit clear done");
        br(3'h2, 21'h100, 16'he67f, 1'b1, 1'b0);
        br(3'h4, 21'h100, 16'he67f, 1'b0, 1'b0);
        br(3'h0, 21'h100, 16'he380, 1'b1, 1'b1);
        br(3'h4, 21'h100, 16'he380, 1'b0, 1'b0);
        br(3'h4, 21'h100, 16'he205, 1'b1, 1'b0);
        br(3'h2, 21'h100, 16'he205, 1'b0, 1'b0);
        br(3'h4, 21'h000, 16'he280, 1'b1, 1'b0);
        wr(bcbx_pkg::OFS_INSTR, 32'h0);
        poll();
        check("bad op status", st & 32'h7, 32'h4);
        $display("test branch done");
        conclude();
    end
endmodule
`default_nettype wire
